//--- logic/intc_consts.svh
/*
  Constants of the interrupt request and vectoring block: register offsets,
  reset values, field positions and sequence counts.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

`define INTC_NUM_SRC 16
`define INTC_VEC_TOP 16'hFFFE
`define INTC_VEC_NONE 6'h3F
`define INTC_IMASK_BIT 3
`define INTC_FRAME_LAST 3'h4
`define INTC_FILL_LAST 3'h2

`define INTC_OFS_FLAG 8'h00
`define INTC_OFS_ENABLE 8'h04
`define INTC_OFS_PENDING 8'h08
`define INTC_OFS_VECTOR 8'h0C
`define INTC_OFS_EVT_STATUS 8'h10
`define INTC_OFS_EVT_MASK 8'h14

`define INTC_EVT_ENTRY 0
`define INTC_EVT_RETURN 1
`define INTC_NUM_EVT 2

`define INTC_RST_ENABLE 16'h0000
`define INTC_RST_EVT_MASK 2'h0
`define INTC_RESP_OKAY 2'h0
`define INTC_RESP_SLVERR 2'h2

`endif

//--- logic/intc_pkg.sv
/*
  Types of the interrupt request and vectoring block.
  Assumes nothing beyond the constants header.
*/
package intc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_POP, ST_FILL} seq_state_e;
  typedef logic [5:0] vec_num_t;
endpackage

//--- logic/intc_vectoring.sv
/*
  Interrupt qualification, stacking, vector fetch and return sequence.
  Assumes a core that flags instruction boundaries, a byte memory that answers
  reads in the same cycle, and an AXI4-Lite master for the registers.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "intc_consts.svh"

module intc_vectoring
  import intc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [`INTC_NUM_SRC-1:0] src_event_i,
  input wire logic inst_done_i,
  input wire logic rti_exec_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] sp_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] ccr_i,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  input wire logic [7:0] mem_rdata_i,
  output logic core_request_o,
  output logic busy_o,
  output logic cpu_load_o,
  output logic [15:0] pc_o,
  output logic [15:0] sp_o,
  output logic [7:0] x_o,
  output logic [7:0] a_o,
  output logic [7:0] ccr_o,
  output logic [23:0] fill_o,
  output logic irq_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);

  ////////////////////////////////////////////////////////////////////////////
  // source map: shared vectors keep separate flags

  function automatic vec_num_t src_vec(input int idx);
    if (idx < 3) begin
      return 6'd39;
    end else if (idx < 7) begin
      return 6'd33;
    end else if (idx < 11) begin
      return 6'd32;
    end else begin
      return 6'(49 - idx);
    end
  endfunction

  // the nonvolatile-memory flags share one enable, receive and fault share one
  function automatic int en_idx(input int idx);
    if (idx < 3) begin
      return 0;
    end else if (idx == 4 || idx == 8) begin
      return idx - 1;
    end else begin
      return idx;
    end
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  seq_state_e state;
  logic [2:0] cnt;
  logic [15:0] work_sp;
  logic [15:0] pc_w;
  logic [7:0] frame [0:4];
  logic [7:0] ccr_hold;
  vec_num_t vec_sel;
  logic [23:0] fill_w;
  logic [`INTC_NUM_SRC-1:0] flag;
  logic [`INTC_NUM_SRC-1:0] enable;
  logic [`INTC_NUM_SRC-1:0] qual;
  logic [`INTC_NUM_EVT-1:0] evt_status;
  logic [`INTC_NUM_EVT-1:0] evt_mask;
  logic [`INTC_NUM_EVT-1:0] evt_set;
  vec_num_t best_vec;
  logic take;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic ar_hs;
  logic [`INTC_NUM_SRC-1:0] flag_clr;
  logic [31:0] w_mask;

  ////////////////////////////////////////////////////////////////////////////
  // qualification and priority

  generate
    for (genvar g = 0; g < `INTC_NUM_SRC; g++) begin : g_qual
      assign qual[g] = flag[g] & enable[en_idx(g)];
    end
  endgenerate

  always_comb begin
    best_vec = `INTC_VEC_NONE;
    for (int i = 0; i < `INTC_NUM_SRC; i++) begin
      if (qual[i] && src_vec(i) < best_vec) begin
        best_vec = src_vec(i);
      end
    end
  end

  assign core_request_o = |qual;
  assign take = (state == ST_IDLE) && inst_done_i && core_request_o && !ccr_i[`INTC_IMASK_BIT] && !rti_exec_i;
  assign busy_o = (state != ST_IDLE);

  // set beats clear so an event during service is never lost
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      flag <= '0;
    end else begin
      flag <= (flag & ~flag_clr) | src_event_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry and return sequencer

  always_comb begin
    mem_addr_o = 16'h0000;
    mem_wdata_o = 8'h00;
    mem_we_o = 1'b0;
    mem_re_o = 1'b0;
    case (state)
      ST_PUSH: begin
        mem_addr_o = work_sp;
        mem_wdata_o = frame[cnt];
        mem_we_o = 1'b1;
      end
      ST_VEC_HI: begin
        mem_addr_o = `INTC_VEC_TOP - {9'h000, vec_sel, 1'b0};
        mem_re_o = 1'b1;
      end
      ST_VEC_LO: begin
        mem_addr_o = `INTC_VEC_TOP - {9'h000, vec_sel, 1'b0} + 16'h0001;
        mem_re_o = 1'b1;
      end
      ST_POP: begin
        mem_addr_o = work_sp + 16'h0001;
        mem_re_o = 1'b1;
      end
      ST_FILL: begin
        mem_addr_o = pc_w + {13'h0000, cnt};
        mem_re_o = 1'b1;
      end
      default: begin
        mem_addr_o = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      work_sp <= 16'h0000;
      pc_w <= 16'h0000;
      ccr_hold <= 8'h00;
      vec_sel <= `INTC_VEC_NONE;
      fill_w <= 24'h000000;
      for (int i = 0; i < 5; i++) begin
        frame[i] <= 8'h00;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 3'h0;
          work_sp <= sp_i;
          if (rti_exec_i) begin
            state <= ST_POP;
          end else if (take) begin
            frame[0] <= pc_i[7:0];
            frame[1] <= pc_i[15:8];
            frame[2] <= x_i;
            frame[3] <= a_i;
            frame[4] <= ccr_i;
            state <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          work_sp <= work_sp - 16'h0001;
          cnt <= cnt + 3'h1;
          if (cnt == `INTC_FRAME_LAST) begin
            ccr_hold <= frame[4] | 8'(1 << `INTC_IMASK_BIT);
            // pick the winner only now, after the frame is out
            vec_sel <= (best_vec == `INTC_VEC_NONE) ? vec_sel : best_vec;
            state <= ST_VEC_HI;
          end
        end
        ST_VEC_HI: begin
          pc_w[15:8] <= mem_rdata_i;
          state <= ST_VEC_LO;
        end
        ST_VEC_LO: begin
          pc_w[7:0] <= mem_rdata_i;
          cnt <= 3'h0;
          state <= ST_FILL;
        end
        ST_POP: begin
          work_sp <= work_sp + 16'h0001;
          cnt <= cnt + 3'h1;
          frame[3'h4 - cnt] <= mem_rdata_i;
          if (cnt == `INTC_FRAME_LAST) begin
            pc_w <= {frame[1], mem_rdata_i};
            ccr_hold <= frame[4];
            cnt <= 3'h0;
            state <= ST_FILL;
          end
        end
        ST_FILL: begin
          fill_w <= {fill_w[15:0], mem_rdata_i};
          cnt <= cnt + 3'h1;
          if (cnt == `INTC_FILL_LAST) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // core register load at the end of either sequence
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cpu_load_o <= 1'b0;
      pc_o <= 16'h0000;
      sp_o <= 16'h0000;
      x_o <= 8'h00;
      a_o <= 8'h00;
      ccr_o <= 8'h00;
      fill_o <= 24'h000000;
    end else begin
      cpu_load_o <= (state == ST_FILL) && (cnt == `INTC_FILL_LAST);
      if (state == ST_FILL && cnt == `INTC_FILL_LAST) begin
        pc_o <= pc_w;
        sp_o <= work_sp;
        x_o <= frame[2];
        a_o <= frame[3];
        ccr_o <= ccr_hold;
        fill_o <= {fill_w[15:0], mem_rdata_i};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt line

  assign evt_set[`INTC_EVT_ENTRY] = take;
  assign evt_set[`INTC_EVT_RETURN] = (state == ST_POP) && (cnt == `INTC_FRAME_LAST);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      evt_status <= '0;
    end else if (ar_hs && s_axi_araddr_i == `INTC_OFS_EVT_STATUS) begin
      evt_status <= evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  assign irq_o = |(evt_status & evt_mask);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign do_write = aw_held && w_held;
  assign w_mask = strb_mask(w_strb);
  assign flag_clr = (do_write && aw_addr == `INTC_OFS_FLAG) ?
                    (w_data[`INTC_NUM_SRC-1:0] & w_mask[`INTC_NUM_SRC-1:0]) : '0;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `INTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if (aw_addr == `INTC_OFS_FLAG || aw_addr == `INTC_OFS_ENABLE || aw_addr == `INTC_OFS_EVT_MASK) begin
          s_axi_bresp_o <= `INTC_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= `INTC_RESP_SLVERR;
        end
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      enable <= `INTC_RST_ENABLE;
      evt_mask <= `INTC_RST_EVT_MASK;
    end else if (do_write && aw_addr == `INTC_OFS_ENABLE) begin
      enable <= (enable & ~w_mask[`INTC_NUM_SRC-1:0]) |
                (w_data[`INTC_NUM_SRC-1:0] & w_mask[`INTC_NUM_SRC-1:0]);
    end else if (do_write && aw_addr == `INTC_OFS_EVT_MASK && w_strb[0]) begin
      evt_mask <= w_data[`INTC_NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `INTC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `INTC_RESP_OKAY;
      if (s_axi_araddr_i == `INTC_OFS_FLAG) begin
        s_axi_rdata_o <= {16'h0000, flag};
      end else if (s_axi_araddr_i == `INTC_OFS_ENABLE) begin
        s_axi_rdata_o <= {16'h0000, enable};
      end else if (s_axi_araddr_i == `INTC_OFS_PENDING) begin
        s_axi_rdata_o <= {16'h0000, qual};
      end else if (s_axi_araddr_i == `INTC_OFS_VECTOR) begin
        s_axi_rdata_o <= {26'h0000000, vec_sel};
      end else if (s_axi_araddr_i == `INTC_OFS_EVT_STATUS) begin
        s_axi_rdata_o <= {30'h00000000, evt_status};
      end else if (s_axi_araddr_i == `INTC_OFS_EVT_MASK) begin
        s_axi_rdata_o <= {30'h00000000, evt_mask};
      end else begin
        s_axi_rdata_o <= 32'h00000000;
        s_axi_rresp_o <= `INTC_RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    src_event_i[0] |=> flag[0]) else $error("event did not set its flag");
  chk_flag_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (src_event_i[5] && flag_clr[5]) |=> flag[5]) else $error("event lost against clear");
  chk_req_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (enable == '0) |-> !core_request_o) else $error("request without enable");
  chk_mask_block: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == ST_IDLE && ccr_i[`INTC_IMASK_BIT] && !rti_exec_i) |=> state != ST_PUSH)
    else $error("masked request taken");
  chk_push_frame: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take |=> (mem_we_o && mem_wdata_o == $past(pc_i[7:0])) ##1 mem_we_o[*4] ##1 state == ST_VEC_HI)
    else $error("stack frame wrong");
  chk_mask_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == ST_VEC_HI) |-> ccr_hold[`INTC_IMASK_BIT]) else $error("mask not set before fetch");
  chk_vec_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == ST_VEC_HI) |=> mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("vector pair split");
  chk_vec_range: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == ST_VEC_HI) |-> (mem_addr_o >= 16'hFFB0 && !mem_addr_o[0])) else $error("vector address bad");
  chk_pop_five: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == ST_IDLE && rti_exec_i) |=> mem_re_o[*5] ##1 state == ST_FILL) else $error("pop length wrong");
  chk_fill_three: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(state == ST_FILL) |-> mem_re_o[*3] ##1 cpu_load_o) else $error("fill not three bytes");
  chk_pc_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    cpu_load_o |-> pc_o == $past(pc_w)) else $error("pc not from vector");

endmodule

//--- test/core_mem_model.sv
/*
  Byte memory at the far side of the vectoring block: stack, vectors, program.
  Assumes reads are answered in the cycle of the read strobe; the bench
  preloads vector bytes through mem.
*/
`timescale 1ns/1ps
module core_mem_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
    end
    last = 8'h00;
  end
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (re_i) begin
      last <= mem[addr_i];
    end
  end
  // unselected: inverse of last byte, so a read taken a cycle late never matches
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule

//--- test/testbench.sv
/*
  Self-checking bench: reset, then a table of sources, then mask and priority cases.
  Assumes the memory model beside the block; the bench plays the core.
*/
`timescale 1ns/1ps
`include "intc_consts.svh"
module testbench;
  import intc_pkg::*;
  localparam logic [15:0] pc0 = 16'h1234;
  localparam logic [15:0] sp0 = 16'h00F0;
  typedef struct packed {logic [4:0] src; logic [4:0] en; vec_num_t vec;} row_s;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] src_event_i = 16'h0000;
  logic inst_done_i = 1'b0;
  logic rti_exec_i = 1'b0;
  logic [15:0] pc_i = pc0;
  logic [15:0] sp_i = sp0;
  logic [7:0] x_i = 8'h5A;
  logic [7:0] a_i = 8'hA5;
  logic [7:0] ccr_i = 8'h00;
  logic [15:0] mem_addr_o, pc_o, sp_o;
  logic [7:0] mem_wdata_o, mem_rdata_i, x_o, a_o, ccr_o;
  logic mem_we_o, mem_re_o, core_request_o, busy_o, cpu_load_o, irq_o;
  logic [23:0] fill_o;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  row_s rows [8] = '{'{5'd0, 5'd0, 6'd39}, '{5'd2, 5'd0, 6'd39}, '{5'd4, 5'd3, 6'd33}, '{5'd5, 5'd5, 6'd33},
    '{5'd8, 5'd7, 6'd32}, '{5'd10, 5'd10, 6'd32}, '{5'd11, 5'd11, 6'd38}, '{5'd15, 5'd15, 6'd34}};

  intc_vectoring dut (.clk_sys_i, .rst_b_i, .src_event_i, .inst_done_i, .rti_exec_i, .pc_i, .sp_i, .x_i, .a_i,
    .ccr_i, .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .core_request_o, .busy_o, .cpu_load_o,
    .pc_o, .sp_o, .x_o, .a_o, .ccr_o, .fill_o, .irq_o, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i);
  core_mem_model mem_m (.clk_i(clk_sys_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .we_i(mem_we_o),
    .re_i(mem_re_o), .rdata_o(mem_rdata_i));

  always #20 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] hnd(input vec_num_t v);
    return 16'h8000 + 16'(v) * 16'h0104;
  endfunction
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // every driver task starts on a rising edge, every pin check but the idle-outputs one after reset sits at a falling edge
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v, output logic [1:0] r);
    logic aw, w, b;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= ad;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      aw = s_axi_awvalid_i & s_axi_awready_o;
      w = s_axi_wvalid_i & s_axi_wready_o;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
    end while (b !== 1'b1);
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= ad;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ar = s_axi_arvalid_i & s_axi_arready_o;
      rv = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ar) s_axi_arvalid_i <= 1'b0;
    end while (rv !== 1'b1);
  endtask
  task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ad, d, r);
    chk(nm, e, d);
    chk("read resp", 32'(`INTC_RESP_OKAY), 32'(r));
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    logic [1:0] r;
    axi_wr(ad, v, r);
    chk("write resp", 32'(`INTC_RESP_OKAY), 32'(r));
  endtask
  task automatic pulse(input logic [15:0] s);
    @(posedge clk_sys_i);
    src_event_i <= s;
    @(posedge clk_sys_i);
    src_event_i <= 16'h0000;
    @(negedge clk_sys_i);
  endtask
  task automatic wait_load();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (cpu_load_o !== 1'b1 && n < 30);
    chk("load pulse", 32'h1, 32'(cpu_load_o));
  endtask
  task automatic entry(input vec_num_t v);
    logic [15:0] h;
    logic [7:0] fr [5];
    h = hnd(v);
    @(posedge clk_sys_i);
    // taken after the edge so a core register changed just before the call is seen settled
    fr = '{pc_i[7:0], pc_i[15:8], x_i, a_i, ccr_i};
    inst_done_i <= 1'b1;
    @(posedge clk_sys_i);
    inst_done_i <= 1'b0;
    wait_load();
    chk("vector pc", 32'(h), 32'(pc_o));
    chk("mask set", 32'(ccr_i | 8'h08), 32'(ccr_o));
    chk("sp after push", 32'(sp_i - 16'd5), 32'(sp_o));
    for (int n = 0; n < 5; n++) chk("stack byte", 32'(fr[n]), 32'(mem_m.mem[sp_i - 16'(n)]));
    chk("handler fill", {8'h00, pat(h), pat(h + 16'd1), pat(h + 16'd2)}, {8'h00, fill_o});
  endtask
  task automatic ret();
    @(posedge clk_sys_i);
    sp_i <= sp0 - 16'd5;
    rti_exec_i <= 1'b1;
    @(posedge clk_sys_i);
    rti_exec_i <= 1'b0;
    sp_i <= sp0;
    wait_load();
    chk("pc back", 32'(pc0), 32'(pc_o));
    chk("sp back", 32'(sp0), 32'(sp_o));
    chk("regs back", {8'h00, x_i, a_i, ccr_i}, {8'h00, x_o, a_o, ccr_o});
    chk("return fill", {8'h00, pat(pc0), pat(pc0 + 16'd1), pat(pc0 + 16'd2)}, {8'h00, fill_o});
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      $display("Error run length expected under 6000 cycles seen %0d", cyc);
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] h;
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int v = 32; v < 40; v++) begin
      h = hnd(vec_num_t'(v));
      mem_m.mem[16'hFFFE - 16'(2 * v)] = h[15:8];
      mem_m.mem[16'hFFFF - 16'(2 * v)] = h[7:0];
    end
    chk("idle outputs", 32'h0, {28'h0, busy_o, core_request_o, irq_o, cpu_load_o});
    rchk("enable reset", `INTC_OFS_ENABLE, 32'(`INTC_RST_ENABLE));
    rchk("evt mask reset", `INTC_OFS_EVT_MASK, 32'(`INTC_RST_EVT_MASK));
    rchk("flag reset", `INTC_OFS_FLAG, 32'h0);
    axi_rd(8'h40, d, r);
    chk("unmapped read", 32'(`INTC_RESP_SLVERR), d | 32'(r));
    axi_wr(8'h44, 32'hFFFF, r);
    chk("unmapped write", 32'(`INTC_RESP_SLVERR), 32'(r));
    rchk("enable kept", `INTC_OFS_ENABLE, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(`INTC_OFS_ENABLE, 32'h1 << rows[i].en);
      pulse(16'h1 << rows[i].src);
      chk("request", 32'h1, 32'(core_request_o));
      rchk("flag set", `INTC_OFS_FLAG, 32'h1 << rows[i].src);
      entry(rows[i].vec);
      wr(`INTC_OFS_FLAG, 32'h1 << rows[i].src);
      @(negedge clk_sys_i);
      chk("request gone", 32'h0, 32'(core_request_o));
      ret();
    end
    $display("test table done");
    wr(`INTC_OFS_ENABLE, 32'h0);
    pulse(16'h2000);
    chk("disabled request", 32'h0, 32'(core_request_o));
    rchk("disabled flag", `INTC_OFS_FLAG, 32'h2000);
    wr(`INTC_OFS_ENABLE, 32'h2000);
    @(posedge clk_sys_i);
    ccr_i <= 8'h08;
    inst_done_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    inst_done_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("masked stays idle", 32'h1, 32'({busy_o, core_request_o}));
    @(posedge clk_sys_i);
    ccr_i <= 8'h00;
    entry(6'd36);
    wr(`INTC_OFS_FLAG, 32'h2000);
    pulse(16'h2000);
    ret();
    rchk("event kept", `INTC_OFS_FLAG, 32'h2000);
    @(negedge clk_sys_i);
    chk("kept request", 32'h1, 32'(core_request_o));
    wr(`INTC_OFS_FLAG, 32'h2000);
    $display("test mask done");
    // clear and new event in the same cycle: the event must win
    fork
      wr(`INTC_OFS_FLAG, 32'h0020);
      begin
        repeat (2) @(posedge clk_sys_i);
        src_event_i <= 16'h0020;
        @(posedge clk_sys_i);
        src_event_i <= 16'h0000;
      end
    join
    rchk("set beats clear", `INTC_OFS_FLAG, 32'h0020);
    wr(`INTC_OFS_FLAG, 32'h0020);
    rchk("flag cleared", `INTC_OFS_FLAG, 32'h0);
    axi_rd(`INTC_OFS_EVT_STATUS, d, r);
    wr(`INTC_OFS_EVT_MASK, 32'h1);
    wr(`INTC_OFS_ENABLE, 32'h8001);
    pulse(16'h8001);
    entry(6'd34);
    chk("irq on entry", 32'h1, 32'(irq_o));
    rchk("evt status entry", `INTC_OFS_EVT_STATUS, 32'h1);
    @(negedge clk_sys_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    wr(`INTC_OFS_FLAG, 32'h8000);
    ret();
    chk("return masked", 32'h0, 32'(irq_o));
    rchk("evt status return", `INTC_OFS_EVT_STATUS, 32'h2);
    entry(6'd39);
    wr(`INTC_OFS_FLAG, 32'h0001);
    ret();
    $display("test priority done");
    stop_test();
  end
endmodule
